// *** shared/ssp_pkg.sv ***
/*
 * Constants for the synchronous serial port control block.
 * Assumes a 32-bit APB slave and an 8-bit serial byte.
 */
package ssp_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] SSP_OFF_BUF  = 8'h00;
    localparam logic [7:0] SSP_OFF_STAT = 8'h04;
    localparam logic [7:0] SSP_OFF_IRQS = 8'h08;
    localparam logic [7:0] SSP_OFF_IRQM = 8'h0c;
    localparam logic [7:0] SSP_OFF_DIR  = 8'h10;
    localparam logic [7:0] SSP_OFF_CTRL = 8'h14;
    // ------------------------------------------------------------
    // Control fields and reset values
    // ------------------------------------------------------------
    localparam int SSP_B_WRITE_COLLISION_FLAG = 7;
    localparam int SSP_B_OVF  = 6;
    localparam int SSP_B_EN   = 5;
    localparam int SSP_B_CKP  = 4;
    localparam logic [7:0] SSP_CTRL_RST = 8'h00;
    localparam logic [1:0] SSP_DIR_RST  = 2'h3;
    // Status bits: buffer full, start seen, stop seen
    localparam int SSP_S_BF = 0;
    localparam int SSP_S_ST = 1;
    localparam int SSP_S_SP = 2;
    // Interrupt bits: byte done, start, stop
    localparam int SSP_I_BYTE = 0;
    localparam int SSP_I_ST   = 1;
    localparam int SSP_I_SP   = 2;
    // ------------------------------------------------------------
    // Mode field codes
    // ------------------------------------------------------------
    localparam logic [3:0] SSP_M_MDIV4  = 4'h0;
    localparam logic [3:0] SSP_M_MDIV16 = 4'h1;
    localparam logic [3:0] SSP_M_MDIV64 = 4'h2;
    localparam logic [3:0] SSP_M_MTMR   = 4'h3;
    localparam logic [3:0] SSP_M_SLVSS  = 4'h4;
    localparam logic [3:0] SSP_M_SLV    = 4'h5;
    localparam logic [3:0] SSP_M_I2C7   = 4'h6;
    localparam logic [3:0] SSP_M_I2C10  = 4'h7;
    localparam logic [3:0] SSP_M_I2CFW  = 4'hb;
    localparam logic [3:0] SSP_M_I2C7I  = 4'he;
    localparam logic [3:0] SSP_M_I2C10I = 4'hf;
    // ------------------------------------------------------------
    // Timing: master divider counts in pclk cycles, and bits per serial byte
    // ------------------------------------------------------------
    localparam logic [5:0] SSP_DIV4  = 6'h03;
    localparam logic [5:0] SSP_DIV16 = 6'h0f;
    localparam logic [5:0] SSP_DIV64 = 6'h3f;
    localparam logic [3:0] SSP_BITS  = 4'h8;
endpackage

// *** rtl/ssp_ctrl.sv ***
/*
 * Synchronous serial port control: SPI master/slave, I2C slave.
 * Assumes pins arrive asynchronously and a pad ring resolves the
 * open-drain and tri-state enables.
 */
// Register access over APB was left to the implementer.
module ssp_ctrl
    import ssp_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        tmr_tick,
    input  wire logic        sck_in,
    output logic             sck_out,
    output logic             sck_oe,
    input  wire logic        serial_data_in_pin,
    output logic             serial_data_out_pin,
    output logic             sdo_oe,
    input  wire logic        ss_n,
    input  wire logic        sda_in,
    output logic             sda_oe,
    output logic             irq
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] ctrl_reg;
    logic [1:0] dir_reg;
    logic [7:0] buf_reg;
    logic [7:0] sr_reg;
    logic [3:0] cnt_reg;
    logic       busy_reg;
    logic       bf_reg;
    logic       st_reg;
    logic       sp_reg;
    logic [2:0] irqs_reg;
    logic [2:0] irqm_reg;
    logic [5:0] div_reg;
    logic       msck_reg;
    logic [1:0] sck_sy_reg;
    logic [1:0] sdi_sy_reg;
    logic [1:0] ss_sy_reg;
    logic [1:0] sda_sy_reg;
    logic       sck_prev_reg;
    logic       sda_prev_reg;

    logic [3:0] mode;
    logic       en;
    logic       clock_polarity_release_bit;
    logic       is_master;
    logic       is_spi;
    logic       is_i2c;
    logic       ss_ctrl;
    logic       ss_hold;
    logic       sck_lvl;
    logic       rise;
    logic       fall;
    logic       rx_edge;
    logic       tx_edge;
    logic       byte_done;
    logic       start_ev;
    logic       stop_ev;
    logic       wr;
    logic       rd;
    logic       buf_wr;
    logic       buf_rd;
    logic       mapped;
    logic       tick;
    logic [5:0] div_max;

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    assign mode = ctrl_reg[3:0];
    assign en   = ctrl_reg[SSP_B_EN];
    assign clock_polarity_release_bit  = ctrl_reg[SSP_B_CKP];
    assign is_master = en && (mode <= SSP_M_MTMR);
    assign is_spi    = en && (mode <= SSP_M_SLV);
    // firmware master code counts as I2C
    assign is_i2c    = en && (mode == SSP_M_I2C7 || mode == SSP_M_I2C10
                       || mode == SSP_M_I2CFW || mode == SSP_M_I2C7I
                       || mode == SSP_M_I2C10I);
    // select control needs mode 4 and input direction
    assign ss_ctrl = en && (mode == SSP_M_SLVSS) && dir_reg[0];
    // select high keeps shift logic held
    assign ss_hold = ss_ctrl && ss_sy_reg[1];

    // Master divider reload
    always_comb
    begin
        case (mode)
            SSP_M_MDIV4:  div_max = SSP_DIV4;
            SSP_M_MDIV16: div_max = SSP_DIV16;
            default:      div_max = SSP_DIV64;
        endcase
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sck_sy_reg <= 2'h0;
            sdi_sy_reg <= 2'h0;
            ss_sy_reg  <= 2'h3;
            sda_sy_reg <= 2'h3;
        end
        else
        begin
            sck_sy_reg <= {sck_sy_reg[0], sck_in};
            sdi_sy_reg <= {sdi_sy_reg[0], serial_data_in_pin};
            ss_sy_reg  <= {ss_sy_reg[0], ss_n};
            sda_sy_reg <= {sda_sy_reg[0], sda_in};
        end
    end

    // ------------------------------------------------------------
    // Clock edges
    // ------------------------------------------------------------
    assign sck_lvl = is_master ? msck_reg : sck_sy_reg[1];
    assign rise    = sck_lvl && !sck_prev_reg;
    assign fall    = !sck_lvl && sck_prev_reg;
    // idle high: tx on falling, rx on rising
    assign tx_edge = is_spi && !ss_hold && (clock_polarity_release_bit ? fall : rise);
    assign rx_edge = (is_spi && !ss_hold && (clock_polarity_release_bit ? rise : fall))
                     || (is_i2c && rise);
    assign byte_done = rx_edge && (cnt_reg == SSP_BITS - 4'h1);
    // I2C start: SDA falls with SCL high; stop: SDA rises
    assign start_ev = is_i2c && sck_sy_reg[1] && !sda_sy_reg[1]
                      && sda_prev_reg;
    assign stop_ev  = is_i2c && sck_sy_reg[1] && sda_sy_reg[1]
                      && !sda_prev_reg;

    // Edge history; clock history loaded with the idle level while held
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sck_prev_reg <= 1'b0;
            sda_prev_reg <= 1'b1;
        end
        else
        begin
            sck_prev_reg <= ss_hold ? clock_polarity_release_bit : sck_lvl;
            sda_prev_reg <= sda_sy_reg[1];
        end
    end

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    assign mapped = (paddr == SSP_OFF_BUF) || (paddr == SSP_OFF_STAT)
                    || (paddr == SSP_OFF_IRQS) || (paddr == SSP_OFF_IRQM)
                    || (paddr == SSP_OFF_DIR) || (paddr == SSP_OFF_CTRL);
    assign wr     = psel && penable && pready && pwrite && mapped;
    assign rd     = psel && penable && pready && !pwrite && mapped;
    assign buf_wr = wr && (paddr == SSP_OFF_BUF);
    assign buf_rd = rd && (paddr == SSP_OFF_BUF);

    // No wait states: ready in the first access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (psel && !penable)
            begin
                case (paddr)
                    SSP_OFF_BUF:  prdata <= {24'h0, buf_reg};
                    SSP_OFF_STAT: prdata <= {29'h0, sp_reg, st_reg, bf_reg};
                    SSP_OFF_IRQS: prdata <= {29'h0, irqs_reg};
                    SSP_OFF_IRQM: prdata <= {29'h0, irqm_reg};
                    SSP_OFF_DIR:  prdata <= {30'h0, dir_reg};
                    SSP_OFF_CTRL: prdata <= {24'h0, ctrl_reg};
                    default:      prdata <= 32'h0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Control register and sticky error flags
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_reg <= SSP_CTRL_RST;
        else
        begin
            if (wr && paddr == SSP_OFF_CTRL)
                ctrl_reg <= pwdata[7:0];
            if (buf_wr && busy_reg)
                ctrl_reg[SSP_B_WRITE_COLLISION_FLAG] <= 1'b1;
            // I2C receive into a full buffer
            if (byte_done && bf_reg && is_i2c)
                ctrl_reg[SSP_B_OVF] <= 1'b1;
            // SPI slave overflow also flagged
            if (byte_done && bf_reg && is_spi && !is_master)
                ctrl_reg[SSP_B_OVF] <= 1'b1;
        end
    end

    // Direction bits: [0] select pin input, [1] data out is input
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            dir_reg <= SSP_DIR_RST;
        else if (wr && paddr == SSP_OFF_DIR)
            dir_reg <= pwdata[1:0];
    end

    // ------------------------------------------------------------
    // Master clock generator
    // ------------------------------------------------------------
    assign tick = (mode == SSP_M_MTMR) ? tmr_tick : (div_reg == 6'h0);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_reg  <= 6'h0;
            msck_reg <= 1'b0;
        end
        else if (!is_master || !busy_reg)
        begin
            div_reg  <= div_max;
            msck_reg <= clock_polarity_release_bit;
        end
        else
        begin
            div_reg <= (div_reg == 6'h0) ? div_max : div_reg - 6'h1;
            if (tick && !(byte_done))
                msck_reg <= !msck_reg;
        end
    end

    // ------------------------------------------------------------
    // Shift engine
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sr_reg   <= 8'h0;
            cnt_reg  <= 4'h0;
            busy_reg <= 1'b0;
        end
        else if (!en)
        begin
            cnt_reg  <= 4'h0;
            busy_reg <= 1'b0;
        end
        else
        begin
            if (buf_wr && !busy_reg)
            begin
                sr_reg   <= pwdata[7:0];
                cnt_reg  <= 4'h0;
                busy_reg <= 1'b1;
            end
            else if (rx_edge)
            begin
                sr_reg  <= {sr_reg[6:0], is_i2c ? sda_sy_reg[1]
                                                : sdi_sy_reg[1]};
                cnt_reg <= byte_done ? 4'h0 : cnt_reg + 4'h1;
                if (byte_done)
                    busy_reg <= 1'b0;
                else if (!is_master)
                    busy_reg <= 1'b1;
            end
            else if (start_ev)
                cnt_reg <= 4'h0;
        end
    end

    // Transmit data pin
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            serial_data_out_pin <= 1'b0;
        else if (buf_wr && !busy_reg)
            serial_data_out_pin <= pwdata[7];
        else if (tx_edge)
            serial_data_out_pin <= sr_reg[7];
    end

    // ------------------------------------------------------------
    // Buffer, status and start/stop tracking
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            buf_reg <= 8'h0;
            bf_reg  <= 1'b0;
        end
        else
        begin
            if (byte_done && !bf_reg)
                buf_reg <= {sr_reg[6:0], is_i2c ? sda_sy_reg[1]
                                                : sdi_sy_reg[1]};
            if (byte_done)
                bf_reg <= 1'b1;
            else if (buf_rd)
                bf_reg <= 1'b0;
        end
    end

    // start/stop bits follow the bus, cleared when disabled
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_reg <= 1'b0;
            sp_reg <= 1'b0;
        end
        else if (!en)
        begin
            st_reg <= 1'b0;
            sp_reg <= 1'b0;
        end
        else if (start_ev)
        begin
            st_reg <= 1'b1;
            sp_reg <= 1'b0;
        end
        else if (stop_ev)
        begin
            st_reg <= 1'b0;
            sp_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Interrupts: W1C status, mask, level output
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irqs_reg <= 3'h0;
            irqm_reg <= 3'h0;
        end
        else
        begin
            if (wr && paddr == SSP_OFF_IRQM)
                irqm_reg <= pwdata[2:0];
            // byte, start and stop events; set beats clear
            irqs_reg <= (irqs_reg & ~((wr && paddr == SSP_OFF_IRQS)
                                      ? pwdata[2:0] : 3'h0))
                        | {stop_ev, start_ev, byte_done};
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(irqs_reg & irqm_reg);
    end

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sdo_oe  <= 1'b0;
            sck_out <= 1'b0;
            sck_oe  <= 1'b0;
            sda_oe  <= 1'b0;
        end
        else
        begin
            // drive when pin is output, unless select control sees select high
            sdo_oe  <= is_spi && !dir_reg[1]
                       && !(ss_ctrl && ss_sy_reg[1]);
            // stretch holds clock low; idle level
            sck_out <= is_master ? msck_reg : 1'b0;
            sck_oe  <= is_master || (is_i2c && !clock_polarity_release_bit);
            sda_oe  <= 1'b0;
        end
    end
endmodule

// *** bench/ssp_ctrl_props.sv ***
/* Checker for the serial port control block.
   Sees only the top ports; bound from the bench top. */
module ssp_ctrl_props
    import ssp_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        tmr_tick,
    input wire logic        sck_in,
    input wire logic        sck_out,
    input wire logic        sck_oe,
    input wire logic        serial_data_in_pin,
    input wire logic        serial_data_out_pin,
    input wire logic        sdo_oe,
    input wire logic        ss_n,
    input wire logic        sda_in,
    input wire logic        sda_oe,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] ctrl_sh;
    logic [1:0] dir_sh;
    logic [2:0] mask_sh;
    logic       sel_mode;
    logic       i2c_rel;
    logic       i2c_on;
    logic       i2c_hold;
    logic       master_sh;
    // Decoded modes from shadow registers
    assign sel_mode = ctrl_sh[SSP_B_EN] && ctrl_sh[3:0] == SSP_M_SLVSS
                      && dir_sh[0];
    assign i2c_on  = ctrl_sh[SSP_B_EN]
                     && ctrl_sh[3:0] inside {SSP_M_I2C7, SSP_M_I2C10,
                     SSP_M_I2CFW, SSP_M_I2C7I, SSP_M_I2C10I};
    assign i2c_rel  = i2c_on && ctrl_sh[SSP_B_CKP];
    assign i2c_hold = i2c_on && !ctrl_sh[SSP_B_CKP];
    assign master_sh = ctrl_sh[SSP_B_EN] && (ctrl_sh[3:0] <= SSP_M_MTMR);
    // Shadow of software writes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_sh <= SSP_CTRL_RST;
            dir_sh <= SSP_DIR_RST;
            mask_sh <= 3'h0;
        end
        else if (psel && penable && pready && pwrite)
        begin
            if (paddr == SSP_OFF_CTRL) ctrl_sh <= pwdata[7:0];
            if (paddr == SSP_OFF_DIR) dir_sh <= pwdata[1:0];
            if (paddr == SSP_OFF_IRQM) mask_sh <= pwdata[2:0];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_PREADY_FIRST: assert property (psel && !penable |=> pready)
        else $error("pready missing in first access cycle");
    AST_PREADY_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_SLVERR_MAP: assert property (pready && paddr[1:0] == 2'h0
        |-> pslverr == (paddr > SSP_OFF_CTRL))
        else $error("pslverr does not match address map");
    AST_ERR_RDATA: assert property (pslverr |-> prdata == 32'h0)
        else $error("refused access returned data");
    AST_SDO_FLOAT: assert property ((sel_mode && ss_n) [*4] |-> !sdo_oe)
        else $error("data output driven while deselected");
    AST_SDO_DRIVE: assert property (
        (sel_mode && !ss_n && !dir_sh[1]) [*5] |-> sdo_oe)
        else $error("data output not driven while selected");
    AST_SDO_INPUT: assert property (dir_sh[1] [*2] |-> !sdo_oe)
        else $error("data output driven while set as input");
    AST_IRQ_MASKED: assert property ((mask_sh == 3'h0) [*2] |-> !irq)
        else $error("interrupt raised while fully masked");
    AST_I2C_RELEASE: assert property (i2c_rel [*2] |-> !sck_oe)
        else $error("clock line held with release bit set");
    AST_I2C_STRETCH: assert property (i2c_hold [*2]
        |-> sck_oe && !sck_out)
        else $error("clock line not held low with release bit clear");
    AST_SCK_QUIET: assert property ((!master_sh) [*2] |-> !sck_out)
        else $error("clock output active outside master modes");
    cover property (i2c_hold ##1 sck_oe);
    cover property ((sel_mode && !ss_n) ##1 ss_n);
    cover property (pslverr);
    cover property (irq);
endmodule

// *** bench/ssp_spi_peer.sv ***
/* External SPI master and I2C master model at the serial pins.
   Link clock 125 ns, stands at its idle level outside frames. */
module ssp_spi_peer
(
    input wire logic clock_polarity_release_bit,
    output logic     sck,
    output logic     mosi,
    output logic     ss_n,
    output logic     sda,
    input wire logic miso
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        sck = 1'b0;
        mosi = 1'b0;
        ss_n = 1'b1;
        sda = 1'b1;
    end
    // One frame, MSB first; optional pause before bit brk
    task automatic xfer(input logic [7:0] tx, input int brk,
                        output logic [7:0] rx);
        // Keep pin changes off the bench clock edges
        #2;
        sck = clock_polarity_release_bit;
        ss_n = 1'b0;
        #125;
        for (int i = 7; i >= 0; i--)
        begin
            if (i == brk)
            begin
                ss_n = 1'b1;
                mosi = ~mosi;
                #500;
                ss_n = 1'b0;
                #125;
            end
            sck = ~clock_polarity_release_bit;
            mosi = tx[i];
            #62.5;
            rx[i] = miso;
            sck = clock_polarity_release_bit;
            #62.5;
        end
        ss_n = 1'b1;
        mosi = ~mosi;
        #125;
    endtask
    // I2C byte between start and stop; ninth clock is a low ack
    task automatic i2c(input logic [7:0] tx);
        #2;
        sck = 1'b1;
        sda = 1'b1;
        #125;
        sda = 1'b0;
        #125;
        for (int i = 8; i >= 0; i--)
        begin
            sck = 1'b0;
            #30;
            sda = (i > 0) ? tx[i - 1] : 1'b0;
            #32.5;
            sck = 1'b1;
            #62.5;
        end
        sda = 1'b1;
        #125;
    endtask
endmodule

// *** bench/ssp_ctrl_tb_top.sv ***
/* Self-checking bench for the serial port control block.
   Drives APB and an SPI master model; checker bound below. */
module ssp_ctrl_tb_top;
    import ssp_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, tmr_tick = 1'b0, clock_polarity_release_bit = 1'b0, sda_in;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, sck_in, sck_out, sck_oe, serial_data_in_pin;
    logic serial_data_out_pin, sdo_oe, ss_n, sda_oe, irq, miso;
    int err_count = 0, check_count = 0, cyc = 0, ovf = 0, write_collision_flag = 0;
    logic [7:0] rx_q[$], ib[2];
    logic [3:0] modes[11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
                              4'h6, 4'h7, 4'hb, 4'he, 4'hf};
    always #5 pclk = ~pclk;
    // Pulled-up data line seen by the master
    assign miso = sdo_oe ? serial_data_out_pin : 1'b1;
    ssp_ctrl ssp_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .tmr_tick, .sck_in,
        .sck_out, .sck_oe, .serial_data_in_pin, .serial_data_out_pin,
        .sdo_oe, .ss_n, .sda_in, .sda_oe, .irq);
    ssp_spi_peer ssp_spi_peer_i (.clock_polarity_release_bit, .sck(sck_in),
        .mosi(serial_data_in_pin), .ss_n, .miso, .sda(sda_in));
    task automatic final_report();
        if (err_count == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, logic xe);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x);
        chk({31'h0, e}, {31'h0, xe});
    endtask
    // Slave byte against the model; col writes the buffer mid-byte
    task automatic spi(input int brk, input logic drv, input logic col);
        logic [7:0] tx, mo, rx;
        tx = 8'($urandom);
        mo = 8'($urandom);
        wr(SSP_OFF_BUF, {24'h0, tx});
        fork
            ssp_spi_peer_i.xfer(mo, brk, rx);
            if (col)
            begin
                #400;
                wr(SSP_OFF_BUF, 32'h0);
                write_collision_flag = 1;
            end
        join
        chk({24'h0, rx}, {24'h0, drv ? tx : 8'hff});
        if (rx_q.size() == 0) rx_q.push_back(mo);
        else ovf = 1;
    endtask
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            final_report();
        end
    end
    initial
    begin
        void'($urandom(53037));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(SSP_OFF_CTRL, 32'h0, 1'b0);
        rd(SSP_OFF_DIR, 32'h3, 1'b0);
        rd(SSP_OFF_STAT, 32'h0, 1'b0);
        rd(8'h40, 32'h0, 1'b1);
        foreach (modes[i])
        begin
            // Release/polarity bit alternates across the modes
            wr(SSP_OFF_CTRL, {24'h0, 3'h1, i[0], modes[i]});
            rd(SSP_OFF_CTRL, {24'h0, 3'h1, i[0], modes[i]}, 1'b0);
        end
        wr(SSP_OFF_CTRL, 32'h0);
        wr(SSP_OFF_DIR, 32'h1);
        wr(SSP_OFF_IRQM, 32'h7);
        wr(SSP_OFF_CTRL, 32'h24);
        spi(-1, 1'b1, 1'b0);
        rd(SSP_OFF_IRQS, 32'h1, 1'b0);
        chk({31'h0, irq}, 32'h1);
        wr(SSP_OFF_IRQS, 32'h1);
        rd(SSP_OFF_IRQS, 32'h0, 1'b0);
        spi(3, 1'b1, 1'b0);
        rd(SSP_OFF_CTRL, 32'h24 | (ovf << 6), 1'b0);
        rd(SSP_OFF_BUF, {24'h0, rx_q.pop_front()}, 1'b0);
        wr(SSP_OFF_CTRL, 32'h24);
        spi(-1, 1'b1, 1'b1);
        rd(SSP_OFF_CTRL, 32'h24 | (write_collision_flag << 7), 1'b0);
        rd(SSP_OFF_BUF, {24'h0, rx_q.pop_front()}, 1'b0);
        wr(SSP_OFF_DIR, 32'h3);
        spi(-1, 1'b0, 1'b0);
        wr(SSP_OFF_IRQM, 32'h0);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        wr(SSP_OFF_IRQM, 32'h1);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        wr(SSP_OFF_IRQS, 32'h7);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        // Idle-high clock: data out on fall, sampled on rise
        clock_polarity_release_bit <= 1'b1;
        wr(SSP_OFF_DIR, 32'h1);
        wr(SSP_OFF_CTRL, 32'h34);
        rd(SSP_OFF_BUF, {24'h0, rx_q.pop_front()}, 1'b0);
        spi(2, 1'b1, 1'b0);
        rd(SSP_OFF_BUF, {24'h0, rx_q.pop_front()}, 1'b0);
        // Two I2C bytes; the second finds the buffer full
        wr(SSP_OFF_CTRL, 32'h36);
        wr(SSP_OFF_IRQS, 32'h7);
        foreach (ib[i])
        begin
            ib[i] = 8'($urandom);
            ssp_spi_peer_i.i2c(ib[i]);
        end
        rd(SSP_OFF_IRQS, 32'h7, 1'b0);
        rd(SSP_OFF_STAT, 32'h5, 1'b0);
        rd(SSP_OFF_CTRL, 32'h76, 1'b0);
        rd(SSP_OFF_BUF, {24'h0, ib[0]}, 1'b0);
        wr(SSP_OFF_CTRL, 32'h16);
        rd(SSP_OFF_STAT, 32'h0, 1'b0);
        final_report();
    end
endmodule
bind ssp_ctrl ssp_ctrl_props ssp_ctrl_props_i (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .tmr_tick, .sck_in, .sck_out, .sck_oe, .serial_data_in_pin,
    .serial_data_out_pin, .sdo_oe, .ss_n, .sda_in, .sda_oe, .irq);
